// ---- lvds_rx_deserializer.sv ----
// Differential serial receiver: deserializer, phase alignment, delay control and read FIFO
//
// Operation
// - Full rate samples on rising edge only
// - Half rate samples on both clock edges
// - Word width programmable up to ten bits
// - Aligned word updated at word clock rise
// - Optional eight-word FIFO into read side
// - Empty flag raised while FIFO holds nothing
// - Reset clears FIFO and deserializer
// - Auto alignment centres sampling in bit
// - Auto alignment only in full rate
// - Lock raised after training completes
// - Buffer enable: one on, zero off
// - Termination control: one on, zero off
// - Step enable drives manual delay or aligner
// - Step up increments, low decrements
// - Delay clear resets counter or aligner
// - New delay takes effect after settling
// - Bypass route only at width one
`timescale 1ns/1ps
module lvds_rx_deserializer
  import lvds_rx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pad_p,
  input wire logic pad_n,
  input wire logic serial_bit_clock,
  input wire logic parallel_word_clock,
  input wire rx_cfg_s cfg,
  input wire logic input_buffer_on,
  input wire logic term_ctrl,
  input wire logic delay_step_enable,
  input wire logic delay_step_up,
  input wire logic delay_clear,
  input wire logic fifo_read_req,
  output logic [WORD_W-1:0] rx_word,
  output logic rx_word_valid,
  output logic fifo_empty,
  output logic lock,
  output logic [TAP_W-1:0] delay_tap,
  output logic bypass_route_out,
  output logic buffer_powered,
  output logic termination_on,
  output logic overflow
);

  // Clamp the configured width into 1..10
  function automatic logic [3:0] eff_width(input logic [3:0] w);
    eff_width = (w == 4'h0 || w > WIDTH_MAX) ? WIDTH_MAX : w;
  endfunction

  // Saturating one-tap step of the delay count
  function automatic logic [TAP_W-1:0] step_tap(input logic [TAP_W-1:0] t, input logic up);
    if (up) begin
      step_tap = (t == '1) ? t : t + 1'b1;
    end else begin
      step_tap = (t == '0) ? t : t - 1'b1;
    end
  endfunction

  // Pin synchronisers
  logic [SYNC_W-1:0] sync1_q, sync2_q, sync3_q;
  logic [SYNC_W-1:0] pins;

  assign pins = {term_ctrl, input_buffer_on, delay_clear, delay_step_up, delay_step_enable,
                 parallel_word_clock, serial_bit_clock, pad_n, pad_p};

  // Two stages of synchronisation, then one extra stage for edge detection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic bit_rise, bit_fall, word_rise, pad_level, step_en_s, step_up_s, clear_s;

  // Edge detection and pad level after the input buffer
  assign bit_rise = sync2_q[S_BIT_CLK] && !sync3_q[S_BIT_CLK];
  assign bit_fall = !sync2_q[S_BIT_CLK] && sync3_q[S_BIT_CLK];
  assign word_rise = sync2_q[S_WORD_CLK] && !sync3_q[S_WORD_CLK];
  assign pad_level = sync2_q[S_BUF_ON] && sync2_q[S_PAD_P] && !sync2_q[S_PAD_N];
  assign step_en_s = sync2_q[S_STEP_EN];
  assign step_up_s = sync2_q[S_STEP_UP];
  assign clear_s = sync2_q[S_CLEAR];

  // Buffer status follows its pin; termination follows its pin in dynamic mode, else the static setting
  assign buffer_powered = sync2_q[S_BUF_ON];
  assign termination_on = cfg.dyn_term_mode ? sync2_q[S_TERM] : cfg.static_term;

  // Aligner is only active in full rate
  logic align_on;
  assign align_on = cfg.auto_align_en && !cfg.half_rate;

  // Delay line and bit phase
  logic [LINE_DEPTH-1:0] line_q, line_d;
  logic [3:0] phase_q, phase_d, period_q, period_d;
  logic pad_prev_q, pad_prev_d;

  // Pad history, phase since the last rising bit clock and measured period
  always_comb begin
    line_d = {line_q[LINE_DEPTH-2:0], pad_level};
    pad_prev_d = pad_level;
    phase_d = (phase_q == PHASE_MAX) ? phase_q : phase_q + 1'b1;
    period_d = period_q;
    if (bit_rise) begin
      phase_d = 4'h0;
      period_d = (phase_q == PHASE_MAX) ? phase_q : phase_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_q <= '0;
      pad_prev_q <= 1'b0;
      phase_q <= '0;
      period_q <= '0;
    end else begin
      line_q <= line_d;
      pad_prev_q <= pad_prev_d;
      phase_q <= phase_d;
      period_q <= period_d;
    end
  end

  // Delay count and phase training
  train_e train_q, train_d;
  logic [TAP_W-1:0] delay_q, delay_d, tap_eff_q [DELAY_SETTLE_CYC];
  logic [3:0] cand_q, cand_d;
  logic [2:0] hits_q, hits_d;
  logic train_go_q, train_go_d;
  logic data_edge;
  logic [4:0] centre;

  assign data_edge = (pad_level != pad_prev_q);
  // Tap that samples half a period after the observed transition
  assign centre = {1'b0, period_q[3:1]} - {1'b0, phase_q};

  // Manual stepping or training, both gated by step enable at the word clock
  always_comb begin
    train_d = train_q;
    delay_d = delay_q;
    cand_d = cand_q;
    hits_d = hits_q;
    train_go_d = train_go_q;
    if (word_rise) begin
      train_go_d = step_en_s && align_on;
      if (clear_s) begin
        if (align_on) begin
          train_d = TRAIN_IDLE;
          hits_d = 3'h0;
        end else begin
          delay_d = DELAY_RESET;
        end
      end else if (step_en_s && !align_on) begin
        delay_d = step_tap(delay_q, step_up_s);
      end
    end
    if (!align_on) begin
      train_d = TRAIN_IDLE;
    end else begin
      unique case (train_q)
        TRAIN_IDLE: begin
          hits_d = 3'h0;
          if (train_go_q && !(word_rise && clear_s)) begin
            train_d = TRAIN_SEEK;
          end
        end
        TRAIN_SEEK: begin
          if (data_edge && period_q != 4'h0) begin
            if (phase_q == cand_q) begin
              hits_d = hits_q + 1'b1;
            end else begin
              cand_d = phase_q;
              hits_d = 3'h1;
            end
            if (phase_q == cand_q && hits_q + 1'b1 == TRAIN_HITS) begin
              train_d = TRAIN_LOCKED;
              delay_d = centre[4] ? TAP_W'(centre + {1'b0, period_q}) : TAP_W'(centre);
            end
          end
        end
        TRAIN_LOCKED: begin
          train_d = TRAIN_LOCKED;
        end
      endcase
      if (word_rise && clear_s) begin
        train_d = TRAIN_IDLE;
      end
    end
  end

  // Training and delay registers; the sampling tap follows after the settle time
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      train_q <= TRAIN_IDLE;
      delay_q <= DELAY_RESET;
      cand_q <= '0;
      hits_q <= '0;
      train_go_q <= 1'b0;
      for (int i = 0; i < DELAY_SETTLE_CYC; i++) begin
        tap_eff_q[i] <= DELAY_RESET;
      end
    end else begin
      train_q <= train_d;
      delay_q <= delay_d;
      cand_q <= cand_d;
      hits_q <= hits_d;
      train_go_q <= train_go_d;
      tap_eff_q[0] <= delay_q;
      for (int i = 1; i < DELAY_SETTLE_CYC; i++) begin
        tap_eff_q[i] <= tap_eff_q[i-1];
      end
    end
  end

  assign lock = align_on && (train_q == TRAIN_LOCKED);
  assign delay_tap = delay_q;

  // Deserializer
  logic sample_now, sbit, word_ok;
  logic [3:0] width;
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [WORD_W-1:0] asm_q, asm_d, ready_word_q, ready_word_d, asm_next;
  logic ready_flag_q, ready_flag_d;

  assign width = eff_width(cfg.word_width);
  assign sample_now = cfg.half_rate ? (bit_rise || bit_fall) : bit_rise;
  assign sbit = line_q[tap_eff_q[DELAY_SETTLE_CYC-1]];
  assign word_ok = !align_on || lock;

  // Assemble bits, first bit in bit 0; unused high bits stay zero
  always_comb begin
    asm_next = (bit_cnt_q == 4'h0) ? WORD_RESET : asm_q;
    asm_next[bit_cnt_q] = sbit;
    asm_d = asm_q;
    bit_cnt_d = bit_cnt_q;
    ready_word_d = ready_word_q;
    ready_flag_d = ready_flag_q;
    if (word_rise) begin
      ready_flag_d = 1'b0;
    end
    if (sample_now) begin
      asm_d = asm_next;
      if (bit_cnt_q + 1'b1 >= width) begin
        bit_cnt_d = 4'h0;
        ready_word_d = asm_next;
        ready_flag_d = 1'b1;
      end else begin
        bit_cnt_d = bit_cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q <= '0;
      asm_q <= WORD_RESET;
      ready_word_q <= WORD_RESET;
      ready_flag_q <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      asm_q <= asm_d;
      ready_word_q <= ready_word_d;
      ready_flag_q <= ready_flag_d;
    end
  end

  // Word presentation and FIFO
  logic present;
  logic [WORD_W-1:0] push_word_q, push_word_d, rx_word_q, rx_word_d;
  logic push_q, push_d, rx_valid_q, rx_valid_d, overflow_q, overflow_d;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [WORD_W-1:0] fifo_out_data;

  assign present = word_rise && ready_flag_q && word_ok;
  assign fifo_pop = cfg.fifo_en && fifo_read_req && fifo_out_valid;

  // Hold a word until the FIFO accepts it; a newer word overwrites and flags overrun
  always_comb begin
    push_d = push_q;
    push_word_d = push_word_q;
    overflow_d = overflow_q;
    rx_word_d = rx_word_q;
    rx_valid_d = 1'b0;
    if (push_q && fifo_in_ready) begin
      push_d = 1'b0;
    end
    if (present) begin
      if (cfg.fifo_en) begin
        push_word_d = ready_word_q;
        push_d = 1'b1;
        if (push_q && !fifo_in_ready) begin
          overflow_d = 1'b1;
        end
      end else begin
        rx_word_d = ready_word_q;
        rx_valid_d = 1'b1;
      end
    end
    if (fifo_pop) begin
      rx_word_d = fifo_out_data;
      rx_valid_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      push_q <= 1'b0;
      push_word_q <= WORD_RESET;
      overflow_q <= 1'b0;
      rx_word_q <= WORD_RESET;
      rx_valid_q <= 1'b0;
    end else begin
      push_q <= push_d;
      push_word_q <= push_word_d;
      overflow_q <= overflow_d;
      rx_word_q <= rx_word_d;
      rx_valid_q <= rx_valid_d;
    end
  end

  // Receive FIFO into the read side; reset clears it together with the deserializer
  rx_word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_word_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Bypass route
  logic bypass_q, bypass_d;

  // Pad level routed out only at deserialization width one
  always_comb begin
    bypass_d = (cfg.word_width == WIDTH_BYPASS) ? pad_level : 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_q <= 1'b0;
    end else begin
      bypass_q <= bypass_d;
    end
  end

  // Outputs
  assign rx_word = rx_word_q;
  assign rx_word_valid = rx_valid_q;
  assign fifo_empty = cfg.fifo_en ? !fifo_out_valid : 1'b1;
  assign overflow = overflow_q;
  assign bypass_route_out = bypass_q;

endmodule

// ---- lvds_rx_pkg.sv ----
// Shared constants and types for the differential serial receive path
package lvds_rx_pkg;

  // Parallel word width and tap range of the emulated input delay chain
  localparam int WORD_W = 10;
  localparam int TAP_W = 4;
  localparam int LINE_DEPTH = 16;
  localparam int FIFO_DEPTH = 8;

  // Reset values and word width limits
  localparam logic [TAP_W-1:0] DELAY_RESET = 4'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;
  localparam logic [3:0] WIDTH_MAX = 4'ha;
  localparam logic [3:0] WIDTH_BYPASS = 4'h1;

  // Phase training: consecutive transitions at one phase needed for lock
  localparam logic [2:0] TRAIN_HITS = 3'h4;
  localparam logic [3:0] PHASE_MAX = 4'hf;

  // Clock rate and delay settle time
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  localparam int DELAY_SETTLE_NS = 5;
  localparam int DELAY_SETTLE_RAW = (DELAY_SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int DELAY_SETTLE_CYC = (DELAY_SETTLE_RAW < 1) ? 1 : DELAY_SETTLE_RAW;

  // Synchroniser bit positions of the pin inputs
  localparam int S_PAD_P = 0;
  localparam int S_PAD_N = 1;
  localparam int S_BIT_CLK = 2;
  localparam int S_WORD_CLK = 3;
  localparam int S_STEP_EN = 4;
  localparam int S_STEP_UP = 5;
  localparam int S_CLEAR = 6;
  localparam int S_BUF_ON = 7;
  localparam int S_TERM = 8;
  localparam int SYNC_W = 9;

  // Static configuration of the receiver
  typedef struct packed {
    logic half_rate;
    logic auto_align_en;
    logic fifo_en;
    logic dyn_term_mode;
    logic static_term;
    logic [3:0] word_width;
  } rx_cfg_s;

  // Phase training states
  typedef enum logic [1:0] {
    TRAIN_IDLE,
    TRAIN_SEEK,
    TRAIN_LOCKED
  } train_e;

endpackage

// ---- rx_word_fifo.sv ----
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rx_word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] COUNT_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PTR_W:0] count_q, count_d;
  logic push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready = (count_q != COUNT_FULL);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count next values; a pop on empty is ignored
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    count_d = count_q;
    if (push) begin
      wr_d = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // Pointer registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      count_q <= count_d;
    end
  end

  // Storage, written at the write pointer
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule

// ---- serial_tx_model.sv ----
// Far-side serial transmitter: differential pads, bit clock and word clock
`timescale 1ns/1ps
module serial_tx_model (
  output logic pad_p,
  output logic pad_n,
  output logic serial_bit_clock,
  output logic parallel_word_clock
);
  // Clocks stand still between frames
  initial begin
    pad_p = 1'b0;
    pad_n = 1'b1;
    serial_bit_clock = 1'b0;
    parallel_word_clock = 1'b0;
  end
  // Drive one differential level
  task automatic level(input logic b);
    pad_p = b;
    pad_n = ~b;
  endtask
  // One word clock rise after the last bit of a word
  task automatic tick();
    parallel_word_clock = 1'b1;
    #200;
    parallel_word_clock = 1'b0;
    #200;
  endtask
  // First bit first; full rate one rise per bit, half rate one edge per bit
  task automatic send(input logic [9:0] data, input int width, input logic half);
    for (int i = 0; i < width; i++) begin
      level(data[i]);
      if (half) begin
        #100;
        serial_bit_clock = ~serial_bit_clock;
        #100;
      end else begin
        #200;
        serial_bit_clock = 1'b1;
        #200;
        serial_bit_clock = 1'b0;
      end
    end
    level(~data[width-1]); // Released line shows the inverse of the last bit
    tick();
  endtask
endmodule

// ---- lvds_rx_sva.sv ----
// Port-level assertions for the differential serial receiver
`timescale 1ns/1ps
module lvds_rx_chk
  import lvds_rx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire rx_cfg_s cfg,
  input wire logic input_buffer_on,
  input wire logic fifo_read_req,
  input wire logic rx_word_valid,
  input wire logic fifo_empty,
  input wire logic lock,
  input wire logic [TAP_W-1:0] delay_tap,
  input wire logic bypass_route_out,
  input wire logic buffer_powered,
  input wire logic termination_on,
  input wire logic overflow
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // Alignment and word delivery
  lock_mode_a: assert property (lock |-> cfg.auto_align_en && !cfg.half_rate)
    else $error("lock outside full rate alignment");
  early_word_a: assert property (
    !cfg.fifo_en && cfg.auto_align_en && !cfg.half_rate && !lock && !$past(lock) |-> !rx_word_valid)
    else $error("word before lock");
  word_pulse_a: assert property (!cfg.fifo_en && rx_word_valid |=> !rx_word_valid)
    else $error("word valid longer than a cycle");
  // Read side of the FIFO
  read_pop_a: assert property (cfg.fifo_en && fifo_read_req && !fifo_empty |=> rx_word_valid)
    else $error("read did not pop");
  read_empty_a: assert property (cfg.fifo_en && fifo_read_req && fifo_empty |=> !rx_word_valid)
    else $error("read while empty popped");
  // Without auto alignment the delay count moves one step at a time or clears
  tap_step_a: assert property (
    !cfg.auto_align_en && delay_tap != $past(delay_tap) |->
    delay_tap == 4'h0 || 4'(delay_tap - $past(delay_tap)) inside {4'h1, 4'hf})
    else $error("delay count jumped");
  // Pin controls
  term_static_a: assert property (!cfg.dyn_term_mode |-> termination_on == cfg.static_term)
    else $error("termination not static");
  buf_follow_a: assert property ($stable(input_buffer_on) [*3] |-> buffer_powered == input_buffer_on)
    else $error("buffer enable not followed");
  bypass_gate_a: assert property (cfg.word_width != WIDTH_BYPASS |-> !bypass_route_out)
    else $error("bypass output outside width one");
  // Main scenarios
  lock_c: cover property ($rose(lock));
  overflow_c: cover property ($rose(overflow));
  tap_top_c: cover property (delay_tap == 4'hf);
endmodule

bind lvds_rx_deserializer lvds_rx_chk chk (.sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg),
  .input_buffer_on(input_buffer_on), .fifo_read_req(fifo_read_req), .rx_word_valid(rx_word_valid),
  .fifo_empty(fifo_empty), .lock(lock), .delay_tap(delay_tap), .bypass_route_out(bypass_route_out),
  .buffer_powered(buffer_powered), .termination_on(termination_on), .overflow(overflow));

// ---- lvds_rx_deserializer_tb.sv ----
// Self-checking bench for the differential serial receiver
`timescale 1ns/1ps
module lvds_rx_deserializer_tb
  import lvds_rx_pkg::*;
;
  typedef struct packed {
    logic half;
    logic [3:0] w;
    logic [9:0] d;
  } row_s;
  localparam row_s ROWS [6] = '{'{1'b0, 4'h8, 10'h0a5}, '{1'b0, 4'ha, 10'h3c6}, '{1'b0, 4'h4, 10'h00d},
    '{1'b0, 4'h0, 10'h2b1}, '{1'b1, 4'h8, 10'h05a}, '{1'b1, 4'ha, 10'h1e3}};
  logic sys_clk, rst_b, input_buffer_on, term_ctrl, delay_step_enable, delay_step_up, delay_clear, fifo_read_req;
  rx_cfg_s cfg;
  wire pad_p, pad_n, serial_bit_clock, parallel_word_clock;
  logic [WORD_W-1:0] rx_word;
  logic [TAP_W-1:0] delay_tap;
  logic rx_word_valid, fifo_empty, lock, bypass_route_out, buffer_powered, termination_on, overflow;
  logic [9:0] got [$];
  int n_mismatch = 0;
  int checked = 0;
  int w;
  int e;

  serial_tx_model tx (.pad_p(pad_p), .pad_n(pad_n), .serial_bit_clock(serial_bit_clock),
    .parallel_word_clock(parallel_word_clock));
  lvds_rx_deserializer uut (.sys_clk(sys_clk), .rst_b(rst_b), .pad_p(pad_p), .pad_n(pad_n),
    .serial_bit_clock(serial_bit_clock), .parallel_word_clock(parallel_word_clock), .cfg(cfg),
    .input_buffer_on(input_buffer_on), .term_ctrl(term_ctrl), .delay_step_enable(delay_step_enable),
    .delay_step_up(delay_step_up), .delay_clear(delay_clear), .fifo_read_req(fifo_read_req),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid), .fifo_empty(fifo_empty), .lock(lock),
    .delay_tap(delay_tap), .bypass_route_out(bypass_route_out), .buffer_powered(buffer_powered),
    .termination_on(termination_on), .overflow(overflow));

  // System clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Collect every presented word
  always @(posedge sys_clk) if (rx_word_valid === 1'b1) got.push_back(rx_word);

  task automatic sync();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic restart(input rx_cfg_s c);
    sync();
    rst_b = 1'b0;
    cfg = c;
    repeat (3) sync();
    rst_b = 1'b1;
    repeat (3) sync();
  endtask
  // One word clock with the delay controls held
  task automatic step(input logic en, input logic up, input logic clr);
    sync();
    delay_step_enable = en;
    delay_step_up = up;
    delay_clear = clr;
    tx.tick();
    sync();
    delay_step_enable = 1'b0;
    delay_clear = 1'b0;
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    n_mismatch++;
    results();
  end

  initial begin
    {rst_b, cfg, term_ctrl, delay_step_enable, delay_step_up, delay_clear, fifo_read_req} = '0;
    input_buffer_on = 1'b1;
    repeat (3) sync();
    check("reset state", {rx_word, rx_word_valid, lock, delay_tap, overflow, fifo_empty}, 18'h00001);
    // Two back-to-back words per mode and width
    foreach (ROWS[i]) begin
      restart('{half_rate: ROWS[i].half, word_width: ROWS[i].w, default: 1'b0});
      w = (ROWS[i].w == 4'h0) ? 10 : ROWS[i].w;
      got.delete();
      tx.send(ROWS[i].d, w, ROWS[i].half);
      tx.send(~ROWS[i].d, w, ROWS[i].half);
      repeat (4) sync();
      check("word count", got.size(), 2);
      check("first word", got[0], ROWS[i].d & (10'h3ff >> (10 - w)));
      check("second word", got[1], ~ROWS[i].d & (10'h3ff >> (10 - w)));
      $display("row %0d done", i);
    end
    // Fill past depth, drain with reads held, then reset in mid-run
    restart('{fifo_en: 1'b1, word_width: 4'h8, default: 1'b0});
    got.delete();
    for (int k = 0; k < 10; k++) tx.send(10'h030 + k, 8, 1'b0);
    check("overflow", overflow, 1'b1);
    check("not empty", fifo_empty, 1'b0);
    fifo_read_req = 1'b1;
    repeat (30) sync();
    fifo_read_req = 1'b0;
    check("read count", got.size(), 9);
    foreach (got[k]) check("fifo word", got[k], (k < 8) ? 10'h030 + k : 10'h039);
    check("drained", fifo_empty, 1'b1);
    tx.send(10'h0ff, 8, 1'b0);
    sync();
    rst_b = 1'b0;
    sync();
    check("reset clears", {fifo_empty, overflow, rx_word_valid}, 3'h4);
    $display("fifo test done");
    // Manual delay stepping with saturation, hold and clear
    restart('{word_width: 4'h8, default: 1'b0});
    e = 0;
    for (int k = 0; k < 36; k++) begin
      step(1'b1, k < 18, 1'b0);
      e = (k < 18) ? ((e == 15) ? 15 : e + 1) : ((e == 0) ? 0 : e - 1);
      check("tap", delay_tap, e);
    end
    step(1'b1, 1'b1, 1'b0);
    step(1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b0);
    check("tap held", delay_tap, 4'h2);
    got.delete();
    tx.send(10'h0c3, 8, 1'b0);
    check("word at new delay", got[0], 10'h0c3);
    step(1'b0, 1'b0, 1'b1);
    check("tap cleared", delay_tap, 4'h0);
    $display("delay test done");
    // Training lock, delivery after lock, clear of the aligner
    restart('{auto_align_en: 1'b1, static_term: 1'b1, word_width: 4'ha, default: 1'b0});
    step(1'b1, 1'b0, 1'b0);
    repeat (6) tx.send(10'h155, 10, 1'b0);
    check("lock", lock, 1'b1);
    got.delete();
    tx.send(10'h155, 10, 1'b0);
    check("words after lock", got.size(), 1);
    check("word after lock", got[0], 10'h155);
    step(1'b0, 1'b0, 1'b1);
    check("lock cleared", lock, 1'b0);
    restart('{half_rate: 1'b1, auto_align_en: 1'b1, word_width: 4'ha, default: 1'b0});
    step(1'b1, 1'b0, 1'b0);
    repeat (4) tx.send(10'h155, 10, 1'b1);
    check("half rate lock", lock, 1'b0);
    $display("align test done");
    // Buffer enable, dynamic termination and bypass route
    restart('{dyn_term_mode: 1'b1, word_width: 4'h1, default: 1'b0});
    for (int k = 0; k < 4; k++) begin
      input_buffer_on = k[1];
      term_ctrl = k[0];
      tx.level(k[0]);
      repeat (5) sync();
      check("bypass", bypass_route_out, k[0] & k[1]);
      check("powered", buffer_powered, k[1]);
      check("termination", termination_on, k[0]);
    end
    $display("pin test done");
    results();
  end
endmodule
